/* File: cds_char_detect_search_sequencer.sv */
// The Wishbone register port and the register addresses are this design's own decisions.
`default_nettype none
module cds_char_detect_search_sequencer (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 rx_lookup_request,
  input  wire logic                 transmit_lookup_request,
  input  wire logic                 rx_active,
  input  wire logic                 tx_active,
  input  wire logic                 tx_running,
  input  wire logic [15:0]          detect_word,
  input  wire logic [15:0]          char_under_test,
  input  wire logic [15:0]          action_memory,
  input  wire logic                 strobe_hit,
  output logic      [3:0]           word_address,
  output cds_pkg::cds_strobe_t      strobe_ctl,
  output logic      [15:0]          action_launch,
  output logic                      char_flag
);
  cds_pkg::cds_state_t state_r;
  logic [3:0]  word_step_counter_r;
  logic [3:0]  match_address_hold_r;
  logic        search_active_r;
  logic        wrap_pending_r;
  logic        end_seen_r;
  logic        rx_sel_r;
  logic        rx_req_r;
  logic        tx_req_r;
  logic        char_flag_r;
  logic [1:0]  ctrl_r;
  logic [15:0] action_launch_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        wb_req;
  logic        wb_wr;
  logic        cnt_load;
  logic        flag_clr;
  logic        increment_phase_ph;
  logic        test_ph;
  logic        done_ph;
  logic        searching;
  logic        carry_out;
  logic        count_en;
  logic        rx_qual;
  logic        tx_qual;
  logic        match;
  logic        flag_hit;
  logic        start;
  logic        pick_rx;
  cds_pkg::cds_status_t status;

  function automatic logic is_reg(input logic [3:0] adr, input logic [3:0] reg_adr);
    is_reg = (adr == reg_adr);
  endfunction

  // bus: one-cycle answer, ack drops the cycle after it is given
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_wr  = wb_req && wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // phases are states of the machine, so each lasts one clock
  assign increment_phase_ph   = (state_r == cds_pkg::CDS_INCREMENT_PHASE);
  assign test_ph   = (state_r == cds_pkg::CDS_TEST);
  assign done_ph   = (state_r == cds_pkg::CDS_DONE);
  assign searching = increment_phase_ph || test_ph;

  assign word_address = word_step_counter_r;
  assign carry_out    = (word_step_counter_r == cds_pkg::WORD_LAST);
  assign match        = (detect_word == char_under_test);

  assign rx_qual = searching && rx_sel_r && !ctrl_r[cds_pkg::CTRL_RX_TOTAL];
  assign tx_qual = searching && !rx_sel_r && !ctrl_r[cds_pkg::CTRL_TX_TRANS];

  // receive wins a tie; the loser stays pending for the next scan
  assign pick_rx = rx_req_r;
  assign start   = (state_r == cds_pkg::CDS_IDLE) && (rx_req_r || tx_req_r)
                   && !wrap_pending_r;

  // transmit steps are held while the transmitter is stalled
  assign count_en = increment_phase_ph && search_active_r && (rx_sel_r || tx_running);

  assign flag_hit = test_ph && rx_qual && match
                    && (action_memory[cds_pkg::ACT_FLAG_A]
                        || action_memory[cds_pkg::ACT_FLAG_B]);

  // loads racing a live search would corrupt the scan address
  assign cnt_load = wb_wr && is_reg(wb_adr_i, cds_pkg::ADR_RCS) && wb_sel_i[1]
                    && !rx_active && !tx_active
                    && (state_r == cds_pkg::CDS_IDLE);
  assign flag_clr = wb_wr && is_reg(wb_adr_i, cds_pkg::ADR_RCS) && wb_sel_i[1]
                    && wb_dat_i[cds_pkg::RCS_FLAG_BIT];

  assign strobe_ctl = '{increment_phase: increment_phase_ph, test_phase: test_ph,
                        search_done: done_ph, rx_lookup_qual: rx_qual,
                        tx_lookup_qual: tx_qual, match_found: searching && match};
  assign action_launch = action_launch_r;
  assign char_flag     = char_flag_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= cds_pkg::CDS_IDLE;
    end else begin
      case (state_r)
        cds_pkg::CDS_IDLE: begin
          if (start) begin
            state_r <= cds_pkg::CDS_INCREMENT_PHASE;
          end
        end
        cds_pkg::CDS_INCREMENT_PHASE: begin
          state_r <= cds_pkg::CDS_TEST;
        end
        cds_pkg::CDS_TEST: begin
          if (end_seen_r) begin
            state_r <= cds_pkg::CDS_DONE;
          end else begin
            state_r <= cds_pkg::CDS_INCREMENT_PHASE;
          end
        end
        cds_pkg::CDS_DONE: begin
          state_r <= cds_pkg::CDS_IDLE;
        end
        default: begin
          state_r <= cds_pkg::CDS_IDLE;
        end
      endcase
    end
  end

  // step counter: first increment of a scan does not count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_step_counter_r <= cds_pkg::CNT_RESET;
    end else if (cnt_load) begin
      word_step_counter_r <= wb_dat_i[cds_pkg::RCS_ADDR_LSB +: 4];
    end else if (count_en) begin
      word_step_counter_r <= word_step_counter_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      search_active_r <= 1'b0;
    end else if (test_ph) begin
      search_active_r <= !end_seen_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrap_pending_r <= 1'b0;
    end else if (test_ph && search_active_r && carry_out && !end_seen_r) begin
      wrap_pending_r <= 1'b1;
    end else if (count_en && carry_out) begin
      wrap_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      end_seen_r <= 1'b0;
    end else if (count_en && carry_out && wrap_pending_r) begin
      end_seen_r <= 1'b1;
    end else if (done_ph) begin
      end_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_sel_r <= 1'b0;
    end else if (start) begin
      rx_sel_r <= pick_rx;
    end
  end

  // a new request in the done cycle survives the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_req_r <= 1'b0;
    end else if (rx_lookup_request) begin
      rx_req_r <= 1'b1;
    end else if (done_ph && rx_sel_r) begin
      rx_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_req_r <= 1'b0;
    end else if (transmit_lookup_request) begin
      tx_req_r <= 1'b1;
    end else if (done_ph && !rx_sel_r) begin
      tx_req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      char_flag_r <= 1'b0;
    end else if (flag_hit) begin
      char_flag_r <= 1'b1;
    end else if (flag_clr) begin
      char_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_address_hold_r <= cds_pkg::CNT_RESET;
    end else if (flag_hit) begin
      match_address_hold_r <= word_step_counter_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      action_launch_r <= 16'h0000;
    end else if (test_ph && strobe_hit && (rx_qual || tx_qual)) begin
      action_launch_r <= action_memory;
    end else begin
      action_launch_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= cds_pkg::CTRL_RESET;
    end else if (wb_wr && is_reg(wb_adr_i, cds_pkg::ADR_CTRL) && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  always_comb begin
    status = '0;
    status.rx_selected       = rx_sel_r;
    status.tx_request        = tx_req_r;
    status.rx_request        = rx_req_r;
    status.wrap_pending      = wrap_pending_r;
    status.search_active     = search_active_r;
    status.word_step_counter = word_step_counter_r;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= wb_req;
      rdat_r <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (is_reg(wb_adr_i, cds_pkg::ADR_RCS)) begin
          rdat_r <= {16'h0000, char_flag_r, 3'h0, match_address_hold_r, 8'h00};
        end else if (is_reg(wb_adr_i, cds_pkg::ADR_CTRL)) begin
          rdat_r <= {30'h0000_0000, ctrl_r};
        end else if (is_reg(wb_adr_i, cds_pkg::ADR_STATUS)) begin
          rdat_r <= status;
        end
      end
    end
  end

  sequence s_phase_pair;
    increment_phase_ph ##1 test_ph;
  endsequence

  property p_increment_phase_then_test;
    @(posedge clk_sys) disable iff (rst)
    increment_phase_ph |=> test_ph;
  endproperty
  a_increment_phase_then_test: assert property (p_increment_phase_then_test) else $error("test missed");

  property p_start_no_count;
    @(posedge clk_sys) disable iff (rst)
    start |=> s_phase_pair ##0 $stable(word_step_counter_r);
  endproperty
  a_start_no_count: assert property (p_start_no_count) else $error("first step counted");

  property p_wrap_halts;
    @(posedge clk_sys) disable iff (rst)
    (count_en && carry_out && wrap_pending_r) |=> (word_step_counter_r == 4'h0)
      ##1 done_ph ##1 (state_r == cds_pkg::CDS_IDLE);
  endproperty
  a_wrap_halts: assert property (p_wrap_halts) else $error("wrap did not halt");

  property p_wrap_set;
    @(posedge clk_sys) disable iff (rst)
    (test_ph && search_active_r && carry_out && !end_seen_r) |=> wrap_pending_r;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap not pending");

  property p_scan_length;
    @(posedge clk_sys) disable iff (rst)
    (start && rx_lookup_request == 1'b0 && word_step_counter_r == 4'h0 && pick_rx)
      |-> ##35 done_ph;
  endproperty
  a_scan_length: assert property (p_scan_length) else $error("scan length wrong");

  property p_tx_qual;
    @(posedge clk_sys) disable iff (rst)
    tx_qual |-> (searching && !rx_sel_r && !ctrl_r[cds_pkg::CTRL_TX_TRANS]);
  endproperty
  a_tx_qual: assert property (p_tx_qual) else $error("tx qualifier wrong");

  property p_rx_total;
    @(posedge clk_sys) disable iff (rst)
    ctrl_r[cds_pkg::CTRL_RX_TOTAL] |-> !rx_qual && !flag_hit;
  endproperty
  a_rx_total: assert property (p_rx_total) else $error("rx detect in transparency");

  property p_hold_capture;
    @(posedge clk_sys) disable iff (rst)
    flag_hit |=> char_flag_r && (match_address_hold_r == $past(word_step_counter_r));
  endproperty
  a_hold_capture: assert property (p_hold_capture) else $error("hold not captured");

  property p_load_idle;
    @(posedge clk_sys) disable iff (rst)
    (rx_active || tx_active || searching) |=> !$past(cnt_load);
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("load while busy");

  property p_done_clears;
    @(posedge clk_sys) disable iff (rst)
    (done_ph && !rx_sel_r && !transmit_lookup_request) |=> !tx_req_r;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("request not cleared");

  property p_single_phase;
    @(posedge clk_sys) disable iff (rst)
    test_ph |=> !test_ph;
  endproperty
  a_single_phase: assert property (p_single_phase) else $error("phase too long");
endmodule
`default_nettype wire

/* File: cds_char_detect_search_sequencer_tb_top.sv */
`default_nettype none
module cds_char_detect_search_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [3:0]           wb_adr_i = 4'h0;
  logic [3:0]           wb_sel_i = 4'hf;
  logic [31:0]          wb_dat_i = 32'h0000_0000;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 rx_lookup_request = 1'b0;
  logic                 transmit_lookup_request = 1'b0;
  logic                 rx_active = 1'b0;
  logic                 tx_active = 1'b0;
  logic                 tx_running = 1'b1;
  logic [15:0]          detect_word;
  logic [15:0]          char_under_test = 16'h0000;
  logic [15:0]          action_memory;
  logic                 strobe_hit;
  logic [3:0]           word_address;
  cds_pkg::cds_strobe_t strobe_ctl;
  logic [15:0]          action_launch;
  logic                 char_flag;
  logic [15:0]          last_launch;
  logic [3:0]           adr_q[$];
  int                   errors = 0;
  int                   checked = 0;
  int                   cyc_cnt = 0;
  int                   n_test, n_txq, n_rxq, n_launch, n_done, n_increment_phase, n_match;

  cds_char_detect_search_sequencer cds_char_detect_search_sequencer_inst (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_lookup_request(rx_lookup_request),
    .transmit_lookup_request(transmit_lookup_request), .rx_active(rx_active),
    .tx_active(tx_active), .tx_running(tx_running), .detect_word(detect_word),
    .char_under_test(char_under_test), .action_memory(action_memory),
    .strobe_hit(strobe_hit), .word_address(word_address), .strobe_ctl(strobe_ctl),
    .action_launch(action_launch), .char_flag(char_flag));

  cds_far_model cds_far_model_inst (
    .word_address(word_address), .char_under_test(char_under_test),
    .detect_word(detect_word), .action_memory(action_memory), .strobe_hit(strobe_hit));

  always #5 clk_sys = ~clk_sys;

  // monitor sees pre-edge values, so no race with the design's flops
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      errors++;
      results();
    end
    if (strobe_ctl.test_phase === 1'b1) begin
      n_test++;
      adr_q.push_back(word_address);
      if (strobe_ctl.tx_lookup_qual === 1'b1) n_txq++;
      if (strobe_ctl.rx_lookup_qual === 1'b1) n_rxq++;
      if (strobe_ctl.match_found === 1'b1) n_match++;
    end
    if (strobe_ctl.increment_phase === 1'b1) n_increment_phase++;
    if (action_launch !== 16'h0000) begin
      n_launch++;
      last_launch = action_launch;
    end
    if (strobe_ctl.search_done === 1'b1) n_done++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // request held until the rising edge that samples ack high
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    chk("wb_ack", 32'(wb_ack_o), 32'h0000_0001);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0000_0000, d);
    chk(nm, d, exp);
  endtask

  task automatic scan(input logic rx, input logic tx, input int ndone);
    int n;
    n_test = 0;
    n_txq = 0;
    n_rxq = 0;
    n_launch = 0;
    n_done = 0;
    n_increment_phase = 0;
    n_match = 0;
    adr_q.delete();
    @(posedge clk_sys);
    rx_lookup_request <= rx;
    transmit_lookup_request <= tx;
    @(posedge clk_sys);
    rx_lookup_request <= 1'b0;
    transmit_lookup_request <= 1'b0;
    n = 0;
    while (n_done < ndone && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (3) @(posedge clk_sys);
    chk("done_cnt", n_done, ndone);
  endtask

  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) rdchk("rst_val", 4'(a), 32'h0000_0000);
    wr(4'hc, 32'hffff_ffff);
    rdchk("unmapped", 4'hc, 32'h0000_0000);
  endtask

  task automatic t_load();
    wr(cds_pkg::ADR_RCS, 32'h0000_0700);
    chk("load_adr", word_address, 32'h0000_0007);
    rdchk("load_stat", cds_pkg::ADR_STATUS, 32'h0000_0007);
    wb_sel_i <= 4'h1;
    wr(cds_pkg::ADR_RCS, 32'h0000_0300);
    chk("sel_load", word_address, 32'h0000_0007);
    wb_sel_i <= 4'hf;
    for (int i = 0; i < 2; i++) begin
      rx_active <= (i == 0);
      tx_active <= (i == 1);
      wr(cds_pkg::ADR_RCS, 32'h0000_0300);
      chk("busy_load", word_address, 32'h0000_0007);
    end
    rx_active <= 1'b0;
    tx_active <= 1'b0;
    wr(cds_pkg::ADR_RCS, 32'h0000_0000);
  endtask

  task automatic t_tx_scan();
    char_under_test <= 16'ha509;
    scan(1'b0, 1'b1, 1);
    chk("n_test", n_test, 17);
    chk("n_increment_phase", n_increment_phase, 17);
    chk("match", n_match, 1);
    for (int i = 0; i < 17; i++) chk("scan_adr", 32'(adr_q[i]), i % 16);
    chk("tx_qual", n_txq, 17);
    chk("launch", last_launch, 32'h0000_0009);
    chk("n_launch", n_launch, 1);
    chk("end_adr", word_address, 32'h0000_0000);
    rdchk("end_stat", cds_pkg::ADR_STATUS, 32'h0000_0000);
  endtask

  task automatic t_rx_flag();
    char_under_test <= 16'ha505;
    scan(1'b1, 1'b0, 1);
    chk("rx_qual", n_rxq, 17);
    chk("flag", char_flag, 32'h0000_0001);
    rdchk("hold", cds_pkg::ADR_RCS, 32'h0000_8500);
    wr(cds_pkg::ADR_RCS, 32'h0000_8000);
    chk("flag_clr", char_flag, 32'h0000_0000);
    wr(cds_pkg::ADR_CTRL, 32'h0000_0002);
    scan(1'b1, 1'b0, 1);
    chk("rx_total", n_rxq + n_launch, 0);
    chk("flag_tot", char_flag, 32'h0000_0000);
    wr(cds_pkg::ADR_CTRL, 32'h0000_0000);
  endtask

  task automatic t_tx_trans();
    wr(cds_pkg::ADR_CTRL, 32'h0000_0001);
    rdchk("ctrl", cds_pkg::ADR_CTRL, 32'h0000_0001);
    char_under_test <= 16'ha509;
    tx_running <= 1'b0;
    // stalled transmitter: counting waits, scan still completes once it runs
    fork
      scan(1'b0, 1'b1, 1);
      begin
        repeat (20) @(posedge clk_sys);
        tx_running <= 1'b1;
      end
    join
    chk("tx_trans", n_txq + n_launch, 0);
    chk("stall_adr", 32'(adr_q[1]), 32'h0000_0000);
    chk("stall_len", 32'(n_test > 17), 32'h0000_0001);
    wr(cds_pkg::ADR_CTRL, 32'h0000_0000);
  endtask

  task automatic t_both();
    char_under_test <= 16'ha509;
    scan(1'b1, 1'b1, 2);
    chk("both_test", n_test, 34);
    chk("both_rx", n_rxq, 17);
    chk("both_tx", n_txq, 17);
    chk("both_launch", n_launch, 2);
  endtask

  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_load();
    t_tx_scan();
    t_rx_flag();
    t_tx_trans();
    t_both();
    results();
  end
endmodule
`default_nettype wire

/* File: cds_far_model.sv */
`default_nettype none
module cds_far_model (
  input  wire logic [3:0]  word_address,
  input  wire logic [15:0] char_under_test,
  output logic      [15:0] detect_word,
  output logic      [15:0] action_memory,
  output logic             strobe_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  // memories answer in the same cycle; no gap for the sequencer to sample stale words
  assign detect_word   = {12'ha50, word_address};
  // word 5 carries the flag bit so a receive match there is reported
  assign action_memory = (word_address == 4'h5) ? 16'h1005 : {12'h000, word_address};
  assign strobe_hit    = (detect_word == char_under_test);
endmodule
`default_nettype wire

/* File: cds_pkg.sv */
`default_nettype none
package cds_pkg;
  localparam logic [3:0] ADR_RCS       = 4'h0;
  localparam logic [3:0] ADR_CTRL      = 4'h4;
  localparam logic [3:0] ADR_STATUS    = 4'h8;
  localparam int         RCS_ADDR_LSB  = 8;
  localparam int         RCS_FLAG_BIT  = 15;
  localparam int         ACT_FLAG_A    = 12;
  localparam int         ACT_FLAG_B    = 13;
  localparam int         CTRL_TX_TRANS = 0;
  localparam int         CTRL_RX_TOTAL = 1;
  localparam logic [3:0] WORD_LAST     = 4'hf;
  localparam logic [3:0] CNT_RESET     = 4'h0;
  localparam logic [1:0] CTRL_RESET    = 2'h0;

  typedef enum {
    CDS_IDLE,
    CDS_INCREMENT_PHASE,
    CDS_TEST,
    CDS_DONE
  } cds_state_t;

  // qualifiers and phases presented to the strobe decoder
  typedef struct packed {
    logic increment_phase;
    logic test_phase;
    logic search_done;
    logic rx_lookup_qual;
    logic tx_lookup_qual;
    logic match_found;
  } cds_strobe_t;

  // status seen by software
  typedef struct packed {
    logic [22:0] zero;
    logic        rx_selected;
    logic        tx_request;
    logic        rx_request;
    logic        wrap_pending;
    logic        search_active;
    logic [3:0]  word_step_counter;
  } cds_status_t;
endpackage
`default_nettype wire
